// [common/arc_pkg.sv]
`default_nettype none
package arc_pkg;

	// ---------------------------------------------------------------
	// Register byte addresses on the APB bus
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B = 8'h04;
	localparam logic [7:0] ADDR_SELECT = 8'h08;
	localparam logic [7:0] ADDR_RES_LOW = 8'h0c;
	localparam logic [7:0] ADDR_RES_HIGH = 8'h10;
	localparam logic [7:0] ADDR_MISC = 8'h14;
	localparam logic [7:0] ADDR_CAL_ADDR = 8'h18;
	localparam logic [7:0] ADDR_CAL_DATA = 8'h1c;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int CA_ENABLE = 7;
	localparam int CA_START = 6;
	localparam int CA_DONE = 4;
	localparam int CB_BIPOLAR = 7;
	localparam int MISC_EXT_REF = 0;
	localparam int MISC_REF_OUT = 1;
	localparam int SEL_DIFF = 4;
	localparam int SEL_HIGH_GAIN = 0;
	localparam logic [7:0] SELECT_RESET = 8'h00;
	localparam logic [2:0] CAL_ADDR_RESET = 3'h0;

	// ---------------------------------------------------------------
	// Conversion lengths in converter clock cycles
	// ---------------------------------------------------------------
	localparam logic [4:0] CONV_NORMAL = 5'h0d;
	localparam logic [4:0] CONV_INIT = 5'h19;
	localparam logic [4:0] CNT_ONE = 5'h01;

	// ---------------------------------------------------------------
	// Result codes and reference codes
	// ---------------------------------------------------------------
	localparam logic [9:0] UNI_MIN = 10'h000;
	localparam logic [9:0] UNI_MAX = 10'h3ff;
	localparam logic [9:0] BIP_MOST_NEG = 10'h200;
	localparam logic [9:0] BIP_MOST_POS = 10'h1ff;
	localparam logic [1:0] REF_CODE_LOW = 2'h1;
	localparam logic [1:0] REF_CODE_HIGH = 2'h3;

	// ---------------------------------------------------------------
	// Calibration row
	// ---------------------------------------------------------------
	localparam logic [2:0] CAL_OFFSET_ADDR = 3'h3;
	localparam logic [2:0] CAL_GAIN_ADDR = 3'h5;

	typedef enum logic [1:0] {
		ARC_REF_SUPPLY,
		ARC_REF_EXTERNAL,
		ARC_REF_INT_LOW,
		ARC_REF_INT_HIGH
	} arc_ref_src_t;

	typedef struct packed {
		logic [1:0] reference_choice;
		logic left_align_result;
		logic [4:0] channel_gain_select;
	} arc_select_t;

	typedef struct packed {
		logic [9:0] single_code;
		logic signed [10:0] diff_code;
	} arc_sample_t;

endpackage : arc_pkg
`default_nettype wire

// [verif/arc_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Analog core stand-in
// ---------------------------------------------------------------
module arc_core_model (
	input wire logic core_busy_q,
	input wire logic core_high_gain_q,
	input wire logic signed [10:0] diff_in,
	input wire logic [9:0] single_in,
	output arc_pkg::arc_sample_t core_sample
);
	int amp;
	always_comb begin
		amp = int'(diff_in) * (core_high_gain_q ? 20 : 8);
		if (amp > 1023)
			amp = 1023;
		if (amp < -1024)
			amp = -1024;
	end
	// Outside a conversion the lines carry inverted values, so a sample
	// taken at the wrong moment cannot look right by chance.
	assign core_sample = core_busy_q ? {single_in, amp[10:0]} :
		~{single_in, amp[10:0]};
endmodule : arc_core_model
`default_nettype wire

// [verif/arc_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module arc_ctrl_tb_top;
	localparam logic [7:0] GAIN_CAL = 8'h9a; // Arbitrary value.
	localparam logic [7:0] OFFS_CAL = 8'hf6; // Arbitrary value.
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	arc_pkg::arc_sample_t core_sample;
	logic core_busy_q;
	logic core_last_q;
	arc_pkg::arc_select_t core_select_q;
	logic core_high_gain_q;
	arc_pkg::arc_ref_src_t core_ref_src_q;
	logic ref_out_drive_q;
	logic ref_out_high_q;
	logic signed [10:0] diff_in = 11'sh000;
	logic [9:0] single_in = 10'h000;
	logic left = 1'b0;
	logic err;
	logic [31:0] rd;
	int fail_count = 0;
	int checks_done = 0;
	int busy_run = 0;
	int last_run = 0;
	int last_at = 0;

	always #2.5 pclk = ~pclk;

	// Busy length is measured here, so a wait that begins mid-conversion
	// still sees the whole conversion.
	always @(posedge pclk) begin
		if (core_busy_q === 1'b1) begin
			busy_run <= busy_run + 1;
			if (core_last_q === 1'b1)
				last_at <= busy_run + 1;
			else if (busy_run == 0)
				last_at <= 0;
		end else begin
			busy_run <= 0;
			if (busy_run > 0)
				last_run <= busy_run;
		end
	end

	arc_ctrl #(.TEMP_GAIN(GAIN_CAL), .TEMP_OFFSET(OFFS_CAL)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
		.core_sample(core_sample), .core_busy_q(core_busy_q),
		.core_last_q(core_last_q), .core_select_q(core_select_q),
		.core_high_gain_q(core_high_gain_q),
		.core_ref_src_q(core_ref_src_q),
		.ref_out_drive_q(ref_out_drive_q), .ref_out_high_q(ref_out_high_q));

	arc_core_model model (.core_busy_q(core_busy_q),
		.core_high_gain_q(core_high_gain_q), .diff_in(diff_in),
		.single_in(single_in), .core_sample(core_sample));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// One idle cycle follows every transfer, so no signal is driven twice
	// in one time step when tasks are called back to back.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_q !== 1'b1 && n < 20);
		rd = prdata_q;
		err = pslverr_q;
		cmp(32'(n), 32'd1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic sel(input logic [1:0] r, input logic l,
		input logic [4:0] ch);
		apb(1'b1, arc_pkg::ADDR_SELECT, {r, l, ch});
		left = l;
	endtask : sel

	task automatic wait_done(input int exp_n);
		int n;
		int t;
		n = 0;
		t = 0;
		while (t < 80 && (n == 0 || core_busy_q === 1'b1)) begin
			if (core_busy_q === 1'b1)
				n++;
			@(posedge pclk);
			t++;
		end
		apb(1'b0, arc_pkg::ADDR_CTRL_A, 8'h00);
		cmp(rd & 32'hd0, 32'h90);
		if (exp_n > 0)
			cmp(32'((n > 0) ? last_run : 0), 32'(exp_n));
		cmp(32'(last_at), 32'(last_run));
		apb(1'b1, arc_pkg::ADDR_CTRL_A, 8'h90);
	endtask : wait_done

	task automatic conv(input int exp_n);
		apb(1'b1, arc_pkg::ADDR_CTRL_A, 8'hc0);
		wait_done(exp_n);
	endtask : conv

	task automatic res(input logic [9:0] r);
		logic [7:0] lo;
		apb(1'b0, arc_pkg::ADDR_RES_LOW, 8'h00);
		lo = rd[7:0];
		apb(1'b0, arc_pkg::ADDR_RES_HIGH, 8'h00);
		if (left)
			cmp({16'h0, rd[7:0], lo}, {16'h0, r, 6'h00});
		else
			cmp({16'h0, rd[7:0], lo}, {22'h0, r});
	endtask : res

	function automatic logic [9:0] expc(input int d, input int g,
		input logic bip);
		int a;
		a = d * g;
		if (a > 1023)
			a = 1023;
		if (a < -1024)
			a = -1024;
		if (bip)
			return a[10:1];
		return (a <= 0) ? 10'h000 : a[9:0];
	endfunction : expc

	task automatic diff_case(input logic [4:0] ch, input int d,
		input logic bip, input int n);
		sel(2'h0, left, ch);
		diff_in <= 11'(d);
		conv(n);
		res(expc(d, ch[0] ? 20 : 8, bip));
	endtask : diff_case

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		apb(1'b0, arc_pkg::ADDR_SELECT, 8'h00);
		cmp(rd, 32'h0);
		apb(1'b0, arc_pkg::ADDR_CTRL_B, 8'h00);
		cmp(rd, 32'h0);
		apb(1'b1, 8'h20, 8'h5a);
		apb(1'b0, 8'h20, 8'h00);
		cmp({rd[30:0], err}, 32'h1);
		cmp(32'(core_ref_src_q), 32'(arc_pkg::ARC_REF_SUPPLY));
	endtask : t_reset

	task automatic t_unipolar;
		diff_case(5'h10, -5, 1'b0, 25);
		diff_case(5'h10, 0, 1'b0, 13);
		diff_case(5'h10, 100, 1'b0, 13);
		diff_case(5'h11, 30, 1'b0, 13);
		cmp(32'(core_high_gain_q), 32'h1);
		diff_case(5'h11, 100, 1'b0, 13);
	endtask : t_unipolar

	task automatic t_bipolar;
		apb(1'b1, arc_pkg::ADDR_CTRL_B, 8'h80);
		diff_case(5'h10, -100, 1'b1, 13);
		diff_case(5'h12, -200, 1'b1, 13);
		diff_case(5'h13, 200, 1'b1, 13);
		sel(2'h0, 1'b0, 5'h03);
		single_in <= 10'h2c5;
		conv(13);
		res(10'h2c5);
		apb(1'b1, arc_pkg::ADDR_CTRL_B, 8'h00);
	endtask : t_bipolar

	task automatic t_align;
		left = 1'b1;
		diff_case(5'h10, 50, 1'b0, 13);
		apb(1'b1, arc_pkg::ADDR_CTRL_A, 8'hc0);
		sel(2'h1, 1'b0, 5'h11);
		cmp(32'(core_select_q), 32'h30);
		cmp(32'(core_ref_src_q), 32'(arc_pkg::ARC_REF_SUPPLY));
		res(10'd400);
		wait_done(13);
		conv(25);
		cmp(32'(core_ref_src_q), 32'(arc_pkg::ARC_REF_INT_LOW));
		res(10'd1000);
	endtask : t_align

	task automatic t_ref;
		apb(1'b1, arc_pkg::ADDR_MISC, 8'h02);
		conv(13);
		cmp(32'({ref_out_drive_q, ref_out_high_q}), 32'h2);
		sel(2'h3, 1'b0, 5'h11);
		conv(25);
		cmp(32'(core_ref_src_q), 32'(arc_pkg::ARC_REF_INT_HIGH));
		cmp(32'({ref_out_drive_q, ref_out_high_q}), 32'h3);
		sel(2'h0, 1'b0, 5'h11);
		apb(1'b1, arc_pkg::ADDR_MISC, 8'h01);
		conv(25);
		cmp(32'(ref_out_drive_q), 32'h0);
		cmp(32'(core_ref_src_q), 32'(arc_pkg::ARC_REF_EXTERNAL));
	endtask : t_ref

	task automatic t_temp;
		apb(1'b1, arc_pkg::ADDR_MISC, 8'h00);
		sel(2'h1, 1'b0, 5'h0b);
		single_in <= 10'h144;
		conv(25);
		res(10'h144);
		cmp(32'(core_ref_src_q), 32'(arc_pkg::ARC_REF_INT_LOW));
	endtask : t_temp

	task automatic t_cal;
		apb(1'b1, arc_pkg::ADDR_CAL_ADDR, 8'h05);
		apb(1'b0, arc_pkg::ADDR_CAL_DATA, 8'h00);
		cmp(rd, {24'h0, GAIN_CAL});
		apb(1'b1, arc_pkg::ADDR_CAL_ADDR, 8'h03);
		apb(1'b0, arc_pkg::ADDR_CAL_DATA, 8'h00);
		cmp(rd, {24'h0, OFFS_CAL});
	endtask : t_cal

	task automatic t_abort;
		apb(1'b1, arc_pkg::ADDR_CTRL_A, 8'hc0);
		apb(1'b1, arc_pkg::ADDR_CTRL_A, 8'h00);
		repeat (30) @(posedge pclk);
		apb(1'b0, arc_pkg::ADDR_CTRL_A, 8'h00);
		cmp(rd & 32'hd0, 32'h0);
		cmp(32'(core_busy_q), 32'h0);
	endtask : t_abort

	// ---------------------------------------------------------------
	// Run control
	// ---------------------------------------------------------------
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_unipolar();
		t_bipolar();
		t_align();
		t_ref();
		t_temp();
		t_cal();
		t_abort();
		complete_run();
	end

	// The full run needs under a thousand cycles; this is 20000 cycles, over twenty times that.
	initial begin
		#100000;
		fail_count++;
		complete_run();
	end
endmodule : arc_ctrl_tb_top
`default_nettype wire

// [verilog/arc_cal_row.sv]
`timescale 1ns/1ps
`default_nettype none
module arc_cal_row #(
	parameter logic [7:0] TEMP_GAIN = 8'h80,
	parameter logic [7:0] TEMP_OFFSET = 8'h00
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] addr,
	output logic [7:0] rdata_q
);

	// ---------------------------------------------------------------
	// Factory row lookup
	// ---------------------------------------------------------------
	// Gain is unsigned in 1/128 units; offset is two's complement.
	wire logic [7:0] row_word;

	assign row_word = (addr == arc_pkg::CAL_GAIN_ADDR) ? TEMP_GAIN :
		(addr == arc_pkg::CAL_OFFSET_ADDR) ? TEMP_OFFSET :
		8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= row_word;
		end
	end

endmodule : arc_cal_row
`default_nettype wire

// [verilog/arc_ctrl.sv]
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module arc_ctrl #(
	parameter logic [7:0] TEMP_GAIN = 8'h80,
	parameter logic [7:0] TEMP_OFFSET = 8'h00
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	input wire arc_pkg::arc_sample_t core_sample,
	output logic core_busy_q,
	output logic core_last_q,
	output arc_pkg::arc_select_t core_select_q,
	output logic core_high_gain_q,
	output arc_pkg::arc_ref_src_t core_ref_src_q,
	output logic ref_out_drive_q,
	output logic ref_out_high_q
);

	// ---------------------------------------------------------------
	// Registers and state
	// ---------------------------------------------------------------
	typedef enum logic {ARC_IDLE, ARC_CONVERT} arc_state_t;

	arc_state_t state_q, state_d;
	logic enable_q, bipolar_q, done_q, init_q;
	logic ext_ref_q, ref_out_en_q;
	logic [7:0] select_q;
	logic [2:0] cal_addr_q;
	logic [4:0] cnt_q, cnt_d;
	logic [1:0] ref_used_q;
	logic [9:0] result_q;
	arc_pkg::arc_select_t act_q;
	wire logic [7:0] cal_rdata;

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	wire logic setup_ph = psel & ~penable;
	wire logic wr_en = psel & penable & pwrite & pready_q;
	wire logic hit_a = (paddr == arc_pkg::ADDR_CTRL_A);
	wire logic hit_b = (paddr == arc_pkg::ADDR_CTRL_B);
	wire logic hit_sel = (paddr == arc_pkg::ADDR_SELECT);
	wire logic hit_lo = (paddr == arc_pkg::ADDR_RES_LOW);
	wire logic hit_hi = (paddr == arc_pkg::ADDR_RES_HIGH);
	wire logic hit_misc = (paddr == arc_pkg::ADDR_MISC);
	wire logic hit_caddr = (paddr == arc_pkg::ADDR_CAL_ADDR);
	wire logic hit_cdata = (paddr == arc_pkg::ADDR_CAL_DATA);
	wire logic mapped = hit_a | hit_b | hit_sel | hit_lo | hit_hi |
		hit_misc | hit_caddr | hit_cdata;

	wire logic wr_a = wr_en & hit_a;
	wire logic enable_d = wr_a ? pwdata[arc_pkg::CA_ENABLE] : enable_q;
	wire logic start_req = wr_a & pwdata[arc_pkg::CA_START] &
		pwdata[arc_pkg::CA_ENABLE];
	wire logic done_clr = wr_a & pwdata[arc_pkg::CA_DONE];

	// ---------------------------------------------------------------
	// Conversion sequencing
	// ---------------------------------------------------------------
	wire logic busy = (state_q == ARC_CONVERT);
	wire logic finish = busy & (cnt_q == arc_pkg::CNT_ONE);
	wire logic begin_conv = (state_q == ARC_IDLE) & start_req;
	wire arc_pkg::arc_select_t sel_now = select_q;
	wire logic ref_change = (sel_now.reference_choice != ref_used_q);
	wire logic long_conv = init_q | ref_change | (enable_d & ~enable_q);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			ARC_IDLE: begin
				if (begin_conv) begin
					state_d = ARC_CONVERT;
					cnt_d = long_conv ? arc_pkg::CONV_INIT :
						arc_pkg::CONV_NORMAL;
				end
			end
			ARC_CONVERT: begin
				if (!enable_d || finish) begin
					state_d = ARC_IDLE;
				end
				cnt_d = cnt_q - arc_pkg::CNT_ONE;
			end
			default: begin
				state_d = ARC_IDLE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Result formatting
	// ---------------------------------------------------------------
	wire logic is_diff = act_q.channel_gain_select[arc_pkg::SEL_DIFF];
	wire logic signed [10:0] diff = core_sample.diff_code;
	wire logic [9:0] uni_code = (diff > 11'sd0) ? diff[9:0] :
		arc_pkg::UNI_MIN;
	// Halving the doubled-range difference gives the 1024-step scale.
	wire logic [9:0] bip_code = diff[10:1];
	wire logic [9:0] conv_code = !is_diff ? core_sample.single_code :
		bipolar_q ? bip_code : uni_code;

	wire logic left = sel_now.left_align_result;
	wire logic [7:0] res_high = left ? result_q[9:2] :
		{6'h00, result_q[9:8]};
	wire logic [7:0] res_low = left ? {result_q[1:0], 6'h00} :
		result_q[7:0];

	// ---------------------------------------------------------------
	// Reference source
	// ---------------------------------------------------------------
	wire logic [1:0] ref_code = sel_now.reference_choice;
	wire arc_pkg::arc_ref_src_t ref_src =
		ext_ref_q ? arc_pkg::ARC_REF_EXTERNAL :
		!ref_code[0] ? arc_pkg::ARC_REF_SUPPLY :
		(ref_code == arc_pkg::REF_CODE_HIGH) ? arc_pkg::ARC_REF_INT_HIGH :
		arc_pkg::ARC_REF_INT_LOW;
	wire logic [1:0] act_ref = act_q.reference_choice;
	wire logic pin_drive = enable_q & ref_out_en_q & act_ref[0];
	wire logic pin_high = (act_ref == arc_pkg::REF_CODE_HIGH);

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	wire logic [7:0] ctrl_a_rd = {enable_q, busy, 1'b0, done_q, 4'h0};
	wire logic [7:0] ctrl_b_rd = {bipolar_q, 7'h00};
	wire logic [7:0] misc_rd = {6'h00, ref_out_en_q, ext_ref_q};
	wire logic [7:0] rd_byte = hit_a ? ctrl_a_rd :
		hit_b ? ctrl_b_rd :
		hit_sel ? select_q :
		hit_lo ? res_low :
		hit_hi ? res_high :
		hit_misc ? misc_rd :
		hit_caddr ? {5'h00, cal_addr_q} :
		hit_cdata ? cal_rdata :
		8'h00;

	// ---------------------------------------------------------------
	// Calibration row
	// ---------------------------------------------------------------
	arc_cal_row #(
		.TEMP_GAIN(TEMP_GAIN),
		.TEMP_OFFSET(TEMP_OFFSET)
	) u_cal_row (
		.pclk(pclk),
		.presetn(presetn),
		.addr(cal_addr_q),
		.rdata_q(cal_rdata)
	);

	// ---------------------------------------------------------------
	// Bus slave flops
	// ---------------------------------------------------------------
	// Read data is captured in the setup cycle, so the access cycle
	// always completes at its first edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= {24'h00_0000, rd_byte};
			pready_q <= setup_ph;
			pslverr_q <= setup_ph & ~mapped;
		end
	end

	// ---------------------------------------------------------------
	// Software registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_q <= 1'b0;
			bipolar_q <= 1'b0;
			select_q <= arc_pkg::SELECT_RESET;
			ext_ref_q <= 1'b0;
			ref_out_en_q <= 1'b0;
			cal_addr_q <= arc_pkg::CAL_ADDR_RESET;
		end else begin
			enable_q <= enable_d;
			if (wr_en && hit_b) begin
				bipolar_q <= pwdata[arc_pkg::CB_BIPOLAR];
			end
			if (wr_en && hit_sel) begin
				select_q <= pwdata[7:0];
			end
			if (wr_en && hit_misc) begin
				ext_ref_q <= pwdata[arc_pkg::MISC_EXT_REF];
				ref_out_en_q <= pwdata[arc_pkg::MISC_REF_OUT];
			end
			if (wr_en && hit_caddr) begin
				cal_addr_q <= pwdata[2:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Converter control flops
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ARC_IDLE;
			cnt_q <= 5'h00;
			done_q <= 1'b0;
			init_q <= 1'b1;
			ref_used_q <= 2'h0;
			result_q <= 10'h000;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			if (finish && enable_d) begin
				result_q <= conv_code;
				done_q <= 1'b1;
			end else if (done_clr) begin
				done_q <= 1'b0;
			end
			if (begin_conv) begin
				init_q <= 1'b0;
			end else if (enable_d && !enable_q) begin
				init_q <= 1'b1;
			end
			if (begin_conv) begin
				ref_used_q <= sel_now.reference_choice;
			end
		end
	end

	// ---------------------------------------------------------------
	// Settings applied to the analog core
	// ---------------------------------------------------------------
	// Settings are copied whenever the next state is idle, so a write during a
	// conversion lands at the same edge as its done flag sets.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_q <= arc_pkg::SELECT_RESET;
			core_select_q <= arc_pkg::SELECT_RESET;
			core_high_gain_q <= 1'b0;
			core_ref_src_q <= arc_pkg::ARC_REF_SUPPLY;
			core_busy_q <= 1'b0;
			core_last_q <= 1'b0;
			ref_out_drive_q <= 1'b0;
			ref_out_high_q <= 1'b0;
		end else begin
			if (state_d == ARC_IDLE || begin_conv) begin
				act_q <= sel_now;
				core_select_q <= sel_now;
				core_high_gain_q <= sel_now.channel_gain_select[
					arc_pkg::SEL_DIFF] & sel_now.channel_gain_select[
					arc_pkg::SEL_HIGH_GAIN];
				core_ref_src_q <= ref_src;
			end
			core_busy_q <= (state_d == ARC_CONVERT);
			core_last_q <= (state_d == ARC_CONVERT) &&
				(cnt_d == arc_pkg::CNT_ONE);
			ref_out_drive_q <= pin_drive;
			ref_out_high_q <= pin_drive & pin_high;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	logic [4:0] len_q;
	logic [4:0] want_q;
	logic was_long_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			len_q <= 5'h00;
			want_q <= 5'h00;
			was_long_q <= 1'b0;
		end else begin
			len_q <= begin_conv ? 5'h00 :
				busy ? len_q + arc_pkg::CNT_ONE : len_q;
			if (begin_conv) begin
				want_q <= cnt_d;
				was_long_q <= ref_change;
			end
		end
	end

	a_uni_clamp: assert property (@(posedge pclk) disable iff (!presetn)
		finish && enable_d && is_diff && !bipolar_q && diff <= 11'sd0
		|=> result_q == arc_pkg::UNI_MIN)
		else $error("unipolar result not clamped");
	a_uni_range: assert property (@(posedge pclk) disable iff (!presetn)
		finish && enable_d && is_diff && !bipolar_q && diff > 11'sd0
		|=> result_q == $past(diff[9:0]))
		else $error("unipolar result wrong");
	a_bip_sign: assert property (@(posedge pclk) disable iff (!presetn)
		finish && enable_d && is_diff && bipolar_q
		|=> result_q[9] == $past(diff[10]))
		else $error("bipolar sign bit wrong");
	a_single_plain: assert property (@(posedge pclk) disable iff (!presetn)
		finish && enable_d && !is_diff
		|=> result_q == $past(core_sample.single_code))
		else $error("single-ended result altered");
	a_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(busy) && $past(finish) |-> len_q == want_q &&
		(len_q == arc_pkg::CONV_NORMAL || len_q == arc_pkg::CONV_INIT))
		else $error("conversion length wrong");
	a_ref_long: assert property (@(posedge pclk) disable iff (!presetn)
		begin_conv && ref_change |=> cnt_q == arc_pkg::CONV_INIT)
		else $error("reference change not long");
	a_sel_held: assert property (@(posedge pclk) disable iff (!presetn)
		busy && !begin_conv ##1 busy |-> $stable(act_q))
		else $error("settings changed mid conversion");
	a_done_set: assert property (@(posedge pclk) disable iff (!presetn)
		finish && enable_d |=> done_q ##1 (done_q || $past(done_clr)))
		else $error("done flag not set");
	a_left_align: assert property (@(posedge pclk) disable iff (!presetn)
		left |-> res_high == result_q[9:2] && res_low[5:0] == 6'h00)
		else $error("left alignment wrong");
	a_ref_pin: assert property (@(posedge pclk) disable iff (!presetn)
		!ref_out_en_q || !enable_q |=> !ref_out_drive_q)
		else $error("reference pin driven while off");

	c_bipolar: cover property (@(posedge pclk) disable iff (!presetn)
		finish && bipolar_q && is_diff && diff < 11'sd0);
	c_clamp: cover property (@(posedge pclk) disable iff (!presetn)
		finish && !bipolar_q && is_diff && diff <= 11'sd0);
	c_long: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(busy) && was_long_q);

endmodule : arc_ctrl
`default_nettype wire
